// ==== src/cfg_bank_pkg.sv ====
// Purpose: constants for the indexed configuration register bank
// Assumes: 25 MHz system clock, AT I/O decode on a 16-bit port address
// Notes: one tag per rule below, carried by the logic that does it
// Overview of operation
// R1: port 22h selects index, 24h moves data
// R2: any data access drops the stored index
// R3: reserved bits reset zero; host writes zero
// R4: exactly twelve indexed registers behind the pair
// R5: control_one bits 7-6 read revision, read-only
// R6: control_one bit 4: early cache buffer enable
// R7: control_one bit 3: single address latch pulse
// R8: control_one bit 2: extra AT wait state
// R9: control_one bit 1: keyboard reset waits halt
// R10: control_one bit 0: fast processor reset path
// R11: control_two bit 7: master mode byte swap
// R12: control_two bit 6: reset now, else 2 us
// R13: control_two bit 5 set disables parity checking
// R14: bit 4 cache on, burst off; 3-2 size
// R15: control_two bit 1: read burst 2-1-1-1 / 3-1-1-1
// R16: control_two bit 0: write hit zero waits
// R17: index and data taken from peripheral byte lane
// R18: cache enable forces DRAM fast decode off
// R19: control_one bit 5 always reads zero
package cfg_bank_pkg;

    // ----------------------------------------------------------------
    // port decode and register window
    // ----------------------------------------------------------------
    localparam logic [15:0] INDEX_PORT_ADDR = 16'h0022;
    localparam logic [15:0] DATA_PORT_ADDR = 16'h0024;
    localparam logic [7:0] FIRST_INDEX = 8'h20;
    localparam int REG_COUNT = 12;
    localparam logic [7:0] CONTROL_ONE_IDX = 8'h20;
    localparam logic [7:0] CONTROL_TWO_IDX = 8'h21;
    localparam logic [7:0] DRAM_CTRL_ONE_IDX = 8'h24;
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    localparam logic [7:0] UNSELECTED_READ = 8'hff;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int C1_REV_LSB = 6;
    localparam int C1_UNUSED_BIT = 5;
    localparam int C1_CACHE_OE_EARLY = 4;
    localparam int C1_SINGLE_ALE = 3;
    localparam int C1_AT_EXTRA_WAIT = 2;
    localparam int C1_KBD_HALT_WAIT = 1;
    localparam int C1_FAST_RESET = 0;
    localparam logic [7:0] C1_WRITE_MASK = 8'h1f;
    localparam int C2_BYTE_SWAP = 7;
    localparam int C2_KBD_FAST = 6;
    localparam int C2_PARITY_OFF = 5;
    localparam int C2_CACHE_EN = 4;
    localparam int C2_CACHE_SIZE_LSB = 2;
    localparam int C2_READ_BURST_FAST = 1;
    localparam int C2_WRITE_ZERO_WAIT = 0;
    localparam int D1_FAST_DECODE = 3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int KBD_RESET_DELAY_NS = 2000;
    localparam int KBD_RESET_DELAY_CYC =
        (KBD_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYC = 16;

    typedef enum logic [1:0] {
        RST_IDLE = 2'b00,
        RST_WAIT_HALT = 2'b01,
        RST_DELAY = 2'b10,
        RST_PULSE = 2'b11
    } rst_state_t;

endpackage

// ==== src/reset_sequencer.sv ====
// Purpose: processor reset pulse from keyboard or fast reset requests
// Assumes: request and halt inputs are one-cycle pulses on i_clk
// Notes: requests arriving while a sequence runs are dropped
`timescale 1ns/100ps
module reset_sequencer (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_kbd_reset_req,
    input wire logic i_fast_reset_req,
    input wire logic i_halt_seen,
    input wire logic i_halt_wait_en,
    input wire logic i_kbd_fast_en,
    input wire logic i_fast_reset_en,
    output logic o_processor_reset_out
);
    cfg_bank_pkg::rst_state_t state_reg, state_next;
    logic [6:0] count_reg, count_next;
    logic rst_out_reg, rst_out_next;

    // ----------------------------------------------------------------
    // sequence control
    // ----------------------------------------------------------------
    // keyboard path may wait for halt, then delay or go straight to pulse
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            cfg_bank_pkg::RST_IDLE: begin
                if (i_fast_reset_req && i_fast_reset_en) begin // R10
                    state_next = cfg_bank_pkg::RST_PULSE;
                    count_next = 7'(cfg_bank_pkg::RESET_PULSE_CYC - 1);
                end else if (i_kbd_reset_req) begin
                    if (i_halt_wait_en) begin
                        state_next = cfg_bank_pkg::RST_WAIT_HALT; // R9
                    end else if (i_kbd_fast_en) begin
                        state_next = cfg_bank_pkg::RST_PULSE; // R12
                        count_next = 7'(cfg_bank_pkg::RESET_PULSE_CYC - 1);
                    end else begin
                        state_next = cfg_bank_pkg::RST_DELAY; // R12
                        count_next = 7'(cfg_bank_pkg::KBD_RESET_DELAY_CYC - 1);
                    end
                end
            end
            cfg_bank_pkg::RST_WAIT_HALT: begin
                if (i_halt_seen) begin // R9
                    if (i_kbd_fast_en) begin
                        state_next = cfg_bank_pkg::RST_PULSE;
                        count_next = 7'(cfg_bank_pkg::RESET_PULSE_CYC - 1);
                    end else begin
                        state_next = cfg_bank_pkg::RST_DELAY;
                        count_next = 7'(cfg_bank_pkg::KBD_RESET_DELAY_CYC - 1);
                    end
                end
            end
            cfg_bank_pkg::RST_DELAY: begin
                if (count_reg == 7'h00) begin
                    state_next = cfg_bank_pkg::RST_PULSE;
                    count_next = 7'(cfg_bank_pkg::RESET_PULSE_CYC - 1);
                end else begin
                    count_next = count_reg - 7'h01;
                end
            end
            cfg_bank_pkg::RST_PULSE: begin
                if (count_reg == 7'h00) begin
                    state_next = cfg_bank_pkg::RST_IDLE;
                end else begin
                    count_next = count_reg - 7'h01;
                end
            end
            default: begin
                state_next = cfg_bank_pkg::RST_IDLE;
                count_next = 7'h00;
            end
        endcase
        rst_out_next = (state_next == cfg_bank_pkg::RST_PULSE);
    end

    // registered so the reset output never glitches
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= cfg_bank_pkg::RST_IDLE;
            count_reg <= 7'h00;
            rst_out_reg <= 1'b0;
        end else if (i_ce) begin
            state_reg <= state_next;
            count_reg <= count_next;
            rst_out_reg <= rst_out_next;
        end
    end

    assign o_processor_reset_out = rst_out_reg;
endmodule // reset_sequencer

// ==== src/indexed_config_register_bank.sv ====
// Purpose: index/data port configuration bank with decoded control outputs
// Assumes: i_io_wr and i_io_rd are one-cycle strobes synchronous to i_clk
// Notes: every output comes from a flip-flop loaded with next-state values
`timescale 1ns/100ps
module indexed_config_register_bank #(
    parameter logic [1:0] REV_CODE = 2'h2 // arbitrary revision value
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [15:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_peripheral_data_byte_lane,
    input wire logic i_kbd_reset_req,
    input wire logic i_fast_reset_req,
    input wire logic i_halt_seen,
    output logic [7:0] o_peripheral_data_byte_lane,
    output logic o_peripheral_data_byte_lane_oe_n,
    output logic o_cache_oe_early,
    output logic o_single_ale,
    output logic o_at_extra_wait,
    output logic o_master_byte_swap,
    output logic o_parity_check_en,
    output logic o_cache_en,
    output logic o_dram_burst_en,
    output logic [1:0] o_cache_size,
    output logic o_read_burst_fast,
    output logic o_write_hit_zero_wait,
    output logic o_dram_fast_decode_en,
    output logic o_processor_reset_out
);
    logic [7:0] regs_reg [cfg_bank_pkg::REG_COUNT];
    logic [7:0] regs_next [cfg_bank_pkg::REG_COUNT];
    logic [7:0] index_reg, index_next;
    logic index_valid_reg, index_valid_next;
    logic [7:0] rdata_reg, rdata_next;
    logic oe_n_reg, oe_n_next;
    logic [7:0] c1, c2, d1;
    logic cache_oe_early_reg, single_ale_reg, at_extra_wait_reg, byte_swap_reg;
    logic parity_en_reg, cache_en_reg, burst_en_reg, read_fast_reg;
    logic write_zero_reg, fast_decode_reg;
    logic [1:0] cache_size_reg;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // index falls inside the twelve-register window
    function automatic logic idx_in_range(input logic [7:0] idx);
        return (idx >= cfg_bank_pkg::FIRST_INDEX) &&
               (idx < 8'(cfg_bank_pkg::FIRST_INDEX + cfg_bank_pkg::REG_COUNT)); // R4
    endfunction

    function automatic logic [3:0] idx_slot(input logic [7:0] idx);
        return 4'(idx - cfg_bank_pkg::FIRST_INDEX);
    endfunction

    // ----------------------------------------------------------------
    // port access
    // ----------------------------------------------------------------
    // index write arms the window; any data access disarms it
    always_comb begin
        logic [3:0] slot;
        logic [7:0] rv;
        slot = idx_slot(index_reg);
        rv = regs_reg[slot];
        regs_next = regs_reg;
        index_next = index_reg;
        index_valid_next = index_valid_reg;
        rdata_next = rdata_reg;
        oe_n_next = 1'b1;
        if (index_reg == cfg_bank_pkg::CONTROL_ONE_IDX) begin
            rv[7:cfg_bank_pkg::C1_REV_LSB] = REV_CODE; // R5
            rv[cfg_bank_pkg::C1_UNUSED_BIT] = 1'b0; // R19
        end
        if (i_io_wr && i_io_addr == cfg_bank_pkg::INDEX_PORT_ADDR) begin // R1
            index_next = i_peripheral_data_byte_lane; // R17
            index_valid_next = 1'b1;
        end
        if ((i_io_wr || i_io_rd) && i_io_addr == cfg_bank_pkg::DATA_PORT_ADDR) begin // R1
            index_valid_next = 1'b0; // R2
            if (i_io_rd) begin
                oe_n_next = 1'b0;
                // a stale or out-of-window index reads as an idle bus
                rdata_next = (index_valid_reg && idx_in_range(index_reg)) ?
                             rv : cfg_bank_pkg::UNSELECTED_READ;
            end
            if (i_io_wr && index_valid_reg && idx_in_range(index_reg)) begin
                if (index_reg == cfg_bank_pkg::CONTROL_ONE_IDX) begin
                    // revision and unused bit never take a write
                    regs_next[slot] = i_peripheral_data_byte_lane &
                                      cfg_bank_pkg::C1_WRITE_MASK; // R5 R19
                end else begin
                    regs_next[slot] = i_peripheral_data_byte_lane; // R17
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // decoded control fields, taken from next values
    // ----------------------------------------------------------------
    assign c1 = regs_next[idx_slot(cfg_bank_pkg::CONTROL_ONE_IDX)];
    assign c2 = regs_next[idx_slot(cfg_bank_pkg::CONTROL_TWO_IDX)];
    assign d1 = regs_next[idx_slot(cfg_bank_pkg::DRAM_CTRL_ONE_IDX)];

    // state and output flops; clock enable low freezes everything
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < cfg_bank_pkg::REG_COUNT; i++) begin
                regs_reg[i] <= cfg_bank_pkg::REG_RESET_VALUE; // R3
            end
            index_reg <= 8'h00;
            index_valid_reg <= 1'b0;
            rdata_reg <= 8'h00;
            oe_n_reg <= 1'b1;
            cache_oe_early_reg <= 1'b0;
            single_ale_reg <= 1'b0;
            at_extra_wait_reg <= 1'b0;
            byte_swap_reg <= 1'b0;
            parity_en_reg <= 1'b1;
            cache_en_reg <= 1'b0;
            burst_en_reg <= 1'b1;
            cache_size_reg <= 2'h0;
            read_fast_reg <= 1'b0;
            write_zero_reg <= 1'b0;
            fast_decode_reg <= 1'b0;
        end else if (i_ce) begin
            regs_reg <= regs_next;
            index_reg <= index_next;
            index_valid_reg <= index_valid_next;
            rdata_reg <= rdata_next;
            oe_n_reg <= oe_n_next;
            cache_oe_early_reg <= c1[cfg_bank_pkg::C1_CACHE_OE_EARLY]; // R6
            single_ale_reg <= c1[cfg_bank_pkg::C1_SINGLE_ALE]; // R7
            at_extra_wait_reg <= c1[cfg_bank_pkg::C1_AT_EXTRA_WAIT]; // R8
            byte_swap_reg <= c2[cfg_bank_pkg::C2_BYTE_SWAP]; // R11
            parity_en_reg <= ~c2[cfg_bank_pkg::C2_PARITY_OFF]; // R13
            cache_en_reg <= c2[cfg_bank_pkg::C2_CACHE_EN]; // R14
            burst_en_reg <= ~c2[cfg_bank_pkg::C2_CACHE_EN]; // R14
            cache_size_reg <= c2[cfg_bank_pkg::C2_CACHE_SIZE_LSB +: 2]; // R14
            read_fast_reg <= c2[cfg_bank_pkg::C2_READ_BURST_FAST]; // R15
            write_zero_reg <= c2[cfg_bank_pkg::C2_WRITE_ZERO_WAIT]; // R16
            // cache use overrides the fast decode setting
            fast_decode_reg <= d1[cfg_bank_pkg::D1_FAST_DECODE] &
                               ~c2[cfg_bank_pkg::C2_CACHE_EN]; // R18
        end
    end

    // ----------------------------------------------------------------
    // reset sequencing
    // ----------------------------------------------------------------
    reset_sequencer u_reset_sequencer (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_kbd_reset_req(i_kbd_reset_req),
        .i_fast_reset_req(i_fast_reset_req),
        .i_halt_seen(i_halt_seen),
        .i_halt_wait_en(regs_reg[idx_slot(cfg_bank_pkg::CONTROL_ONE_IDX)]
                        [cfg_bank_pkg::C1_KBD_HALT_WAIT]), // R9
        .i_kbd_fast_en(regs_reg[idx_slot(cfg_bank_pkg::CONTROL_TWO_IDX)]
                       [cfg_bank_pkg::C2_KBD_FAST]), // R12
        .i_fast_reset_en(regs_reg[idx_slot(cfg_bank_pkg::CONTROL_ONE_IDX)]
                         [cfg_bank_pkg::C1_FAST_RESET]), // R10
        .o_processor_reset_out(o_processor_reset_out)
    );

    assign o_peripheral_data_byte_lane = rdata_reg;
    assign o_peripheral_data_byte_lane_oe_n = oe_n_reg;
    assign o_cache_oe_early = cache_oe_early_reg;
    assign o_single_ale = single_ale_reg;
    assign o_at_extra_wait = at_extra_wait_reg;
    assign o_master_byte_swap = byte_swap_reg;
    assign o_parity_check_en = parity_en_reg;
    assign o_cache_en = cache_en_reg;
    assign o_dram_burst_en = burst_en_reg;
    assign o_cache_size = cache_size_reg;
    assign o_read_burst_fast = read_fast_reg;
    assign o_write_hit_zero_wait = write_zero_reg;
    assign o_dram_fast_decode_en = fast_decode_reg;
endmodule // indexed_config_register_bank

// ==== test/cfg_bank_assertions.sv ====
// Purpose: port-level checks for the configuration bank
// Assumes: host leaves one idle cycle between strobes
// Notes: bound to every instance of the bank
`timescale 1ns/100ps
module cfg_bank_assertions #(
    parameter logic [1:0] REV_CODE = 2'h2
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [15:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_peripheral_data_byte_lane,
    input wire logic [7:0] o_peripheral_data_byte_lane,
    input wire logic o_peripheral_data_byte_lane_oe_n,
    input wire logic o_at_extra_wait,
    input wire logic o_parity_check_en,
    input wire logic o_cache_en,
    input wire logic o_dram_burst_en,
    input wire logic o_dram_fast_decode_en,
    input wire logic o_processor_reset_out
);
    logic [7:0] hi_reg;
    logic [7:0] hi_next;
    logic at_idx;
    logic at_dat;
    default clocking cb @(posedge i_clk); endclocking
    // a frozen bank takes no access, so checks pause while enable is low
    default disable iff (!i_rstn || !i_ce);
    assign at_idx = i_io_addr == cfg_bank_pkg::INDEX_PORT_ADDR;
    assign at_dat = i_io_addr == cfg_bank_pkg::DATA_PORT_ADDR;
    // length of the running reset pulse, zero between pulses
    always_comb hi_next = o_processor_reset_out ? hi_reg + 8'h01 : 8'h00;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) hi_reg <= 8'h00;
        else hi_reg <= hi_next;
    end
    sequence sel(logic [7:0] idx);
        i_io_wr && at_idx && i_peripheral_data_byte_lane == idx;
    endsequence
    sequence dat_wr; i_io_wr && at_dat; endsequence
    sequence dat_rd; i_io_rd && at_dat; endsequence
    burst_vs_cache_a: assert property (o_dram_burst_en == !o_cache_en)
        else $error("burst enable not inverse of cache enable");
    fast_decode_off_a: assert property (o_cache_en |-> !o_dram_fast_decode_en)
        else $error("fast decode on with cache enabled");
    c2_fields_a: assert property (sel(8'h21) ##2 dat_wr |=>
        o_cache_en == $past(i_peripheral_data_byte_lane[4])
        && o_parity_check_en == !$past(i_peripheral_data_byte_lane[5]))
        else $error("control_two write not reflected");
    c1_wait_a: assert property (sel(8'h20) ##2 dat_wr |=>
        o_at_extra_wait == $past(i_peripheral_data_byte_lane[2]))
        else $error("extra wait bit not reflected");
    rev_read_a: assert property (sel(8'h20) ##2 dat_rd |=>
        !o_peripheral_data_byte_lane_oe_n
        && o_peripheral_data_byte_lane[7:5] == {REV_CODE, 1'b0})
        else $error("control_one read lacks revision");
    stale_read_a: assert property ((i_io_wr || i_io_rd) && at_dat ##2 dat_rd |=>
        o_peripheral_data_byte_lane == 8'hff)
        else $error("read without index returned data");
    oe_cause_a: assert property ($fell(o_peripheral_data_byte_lane_oe_n) |->
        $past(i_io_rd && at_dat))
        else $error("read answer without data port read");
    cfg_hold_a: assert property ($changed({o_at_extra_wait, o_cache_en}) |->
        $past(i_io_wr && at_dat))
        else $error("config output moved without data write");
    pulse_width_a: assert property ($fell(o_processor_reset_out) |-> hi_reg == 8'h10)
        else $error("processor reset pulse width wrong");
endmodule // cfg_bank_assertions
bind indexed_config_register_bank cfg_bank_assertions #(.REV_CODE(REV_CODE)) i_checks (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_io_addr(i_io_addr),
    .i_io_wr(i_io_wr),
    .i_io_rd(i_io_rd),
    .i_peripheral_data_byte_lane(i_peripheral_data_byte_lane),
    .o_peripheral_data_byte_lane(o_peripheral_data_byte_lane),
    .o_peripheral_data_byte_lane_oe_n(o_peripheral_data_byte_lane_oe_n),
    .o_at_extra_wait(o_at_extra_wait),
    .o_parity_check_en(o_parity_check_en),
    .o_cache_en(o_cache_en),
    .o_dram_burst_en(o_dram_burst_en),
    .o_dram_fast_decode_en(o_dram_fast_decode_en),
    .o_processor_reset_out(o_processor_reset_out)
);

// ==== test/host_io_model.sv ====
// Purpose: host processor doing AT I/O port cycles on the bank
// Assumes: strobes launched on falling edges, one cycle wide
// Notes: a released bus shows inverted last values so stale data never matches
`timescale 1ns/100ps
module host_io_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_oe_n,
    output logic [15:0] o_io_addr,
    output logic o_io_wr,
    output logic o_io_rd,
    output logic [7:0] o_wr_data
);
    initial begin
        {o_io_addr, o_io_wr, o_io_rd, o_wr_data} = '0;
    end
    // one strobe cycle; the answer is taken at the closing falling edge
    task automatic io(input logic w, input logic r, input logic [15:0] a,
                      input logic [7:0] d, output logic [7:0] got, output logic oe_n);
        @(negedge i_clk);
        {o_io_addr, o_io_wr, o_io_rd, o_wr_data} = {a, w, r, d};
        @(negedge i_clk);
        got = i_rd_data;
        oe_n = i_rd_oe_n;
        {o_io_addr, o_io_wr, o_io_rd, o_wr_data} = {~a, 2'b00, ~d};
    endtask
    // fresh index before every data access, even to the same register
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] v);
        logic [7:0] g;
        logic o;
        io(1'b1, 1'b0, cfg_bank_pkg::INDEX_PORT_ADDR, idx, g, o);
        io(1'b1, 1'b0, cfg_bank_pkg::DATA_PORT_ADDR, v, g, o);
    endtask
    task automatic reg_rd(input logic [7:0] idx, output logic [7:0] v, output logic o);
        io(1'b1, 1'b0, cfg_bank_pkg::INDEX_PORT_ADDR, idx, v, o);
        io(1'b0, 1'b1, cfg_bank_pkg::DATA_PORT_ADDR, 8'h00, v, o);
    endtask
endmodule // host_io_model

// ==== test/indexed_config_register_bank_test.sv ====
// Purpose: self-checking bench for the configuration bank
// Assumes: 25 MHz clock, clock enable high except in the freeze step
// Notes: reset requests driven directly, register traffic via the host model
`timescale 1ns/100ps
module indexed_config_register_bank_test;
    localparam logic [1:0] REV = 2'h1; // arbitrary revision value
    localparam logic [15:0] DAT = cfg_bank_pkg::DATA_PORT_ADDR;
    logic clk, rstn, kbd, fast, halt, wr, rd, oe_n, c1_oe, c1_ale, c1_wait, swap, par;
    logic ce, cen, burst, rbf, whz, fdec, cpu_rst;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, c1v, c2v;
    logic [1:0] csize;
    int fail_count = 0;
    int cmp_count = 0;
    assign c1v = {3'h0, c1_oe, c1_ale, c1_wait, 2'h0};
    // bit 6 has no output; it reads one if burst enable fails to be the inverse of cache enable
    assign c2v = {swap, ~(cen ^ burst), ~par, cen, csize, rbf, whz};
    indexed_config_register_bank #(.REV_CODE(REV)) i_dut (
        .i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_io_addr(addr), .i_io_wr(wr),
        .i_io_rd(rd), .i_peripheral_data_byte_lane(wdata), .i_kbd_reset_req(kbd),
        .i_fast_reset_req(fast), .i_halt_seen(halt), .o_peripheral_data_byte_lane(rdata),
        .o_peripheral_data_byte_lane_oe_n(oe_n), .o_cache_oe_early(c1_oe),
        .o_single_ale(c1_ale), .o_at_extra_wait(c1_wait), .o_master_byte_swap(swap),
        .o_parity_check_en(par), .o_cache_en(cen), .o_dram_burst_en(burst),
        .o_cache_size(csize), .o_read_burst_fast(rbf), .o_write_hit_zero_wait(whz),
        .o_dram_fast_decode_en(fdec), .o_processor_reset_out(cpu_rst));
    host_io_model i_host (.i_clk(clk), .i_rd_data(rdata), .i_rd_oe_n(oe_n),
        .o_io_addr(addr), .o_io_wr(wr), .o_io_rd(rd), .o_wr_data(wdata));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // reset values, then every single bit and every cache size code
    task automatic t_regs();
        logic [7:0] vals [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                                  8'h0c, 8'h00};
        logic [7:0] v;
        logic o;
        check("reset c2 outputs", c2v, 8'h00);
        check("reset c1 outputs", c1v, 8'h00);
        foreach (vals[i]) begin
            i_host.reg_wr(8'h21, vals[i]);
            check("c2 outputs", c2v, vals[i] & 8'hbf);
            i_host.reg_rd(8'h21, v, o);
            check("control_two", v, vals[i]);
            check("read enable", {7'h0, o}, 8'h00);
            i_host.reg_wr(8'h20, vals[i] & 8'hdf);
            check("c1 outputs", c1v, vals[i] & 8'h1c);
            i_host.reg_rd(8'h20, v, o);
            check("control_one", v, {REV, 1'b0, vals[i][4:0]});
        end
        $display("test registers done");
    endtask
    // index invalidation, upper window edge, fast decode override
    task automatic t_index();
        logic [7:0] v;
        logic o;
        i_host.reg_wr(8'h21, 8'h10);
        i_host.io(1'b1, 1'b0, DAT, 8'h00, v, o);
        i_host.io(1'b0, 1'b1, DAT, 8'h00, v, o);
        check("stale read", v, 8'hff);
        i_host.reg_rd(8'h21, v, o);
        check("control_two kept", v, 8'h10);
        i_host.reg_wr(8'h24, 8'h08);
        check("decode with cache", {7'h0, fdec}, 8'h00);
        i_host.reg_wr(8'h21, 8'h00);
        check("decode no cache", {7'h0, fdec}, 8'h01);
        i_host.reg_wr(8'h2b, 8'h5a);
        i_host.reg_rd(8'h2b, v, o);
        check("last register", v, 8'h5a);
        i_host.reg_rd(8'h2c, v, o);
        check("beyond window", v, 8'hff);
        i_host.io(1'b0, 1'b1, cfg_bank_pkg::INDEX_PORT_ADDR, 8'h00, v, o);
        check("index port read", {7'h0, o}, 8'h01);
        // enable low: a full index and data write must leave nothing behind
        ce = 1'b0;
        i_host.reg_wr(8'h21, 8'h10);
        check("frozen outputs", c2v, 8'h00);
        ce = 1'b1;
        i_host.reg_rd(8'h21, v, o);
        check("frozen register", v, 8'h00);
        $display("test index done");
    endtask
    // sel 0 fast, 1 keyboard, 2 halt; a missing pulse that was due ends the run
    task automatic pulse(input int sel, input bit due, output int lat, output int wid);
        @(negedge clk);
        {fast, kbd, halt} = 3'b100 >> sel;
        @(negedge clk);
        {fast, kbd, halt} = 3'b000;
        lat = 1;
        wid = 0;
        while (cpu_rst !== 1'b1 && lat < 120) begin
            @(negedge clk);
            lat++;
        end
        while (cpu_rst === 1'b1 && wid < 40) begin
            wid++;
            @(negedge clk);
        end
        if (due && lat == 120) begin
            fail_count++;
            test_done();
        end
    endtask
    task automatic t_resets();
        int lat, wid;
        pulse(0, 1'b0, lat, wid);
        check("fast reset off", 8'(wid), 8'h00);
        i_host.reg_wr(8'h20, 8'h01);
        pulse(0, 1'b1, lat, wid);
        check("fast latency", 8'(lat), 8'h01);
        check("pulse width", 8'(wid), 8'h10);
        i_host.reg_wr(8'h20, 8'h00);
        pulse(1, 1'b1, lat, wid);
        check("kbd 2 us", 8'(lat), 8'(cfg_bank_pkg::KBD_RESET_DELAY_CYC + 1));
        i_host.reg_wr(8'h21, 8'h40);
        pulse(1, 1'b1, lat, wid);
        check("kbd at once", 8'(lat), 8'h01);
        i_host.reg_wr(8'h20, 8'h02);
        pulse(1, 1'b0, lat, wid);
        check("wait for halt", 8'(wid), 8'h00);
        pulse(2, 1'b1, lat, wid);
        check("after halt", 8'(lat), 8'h01);
        $display("test resets done");
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rstn, kbd, fast, halt} = 4'h0;
        ce = 1'b1;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        t_regs();
        t_index();
        t_resets();
        test_done();
    end
endmodule // indexed_config_register_bank_test
